// >>> design/dbc_config_bank.sv
// Configuration register bank for a pair of buck channels.
// Assumes the serial control block presents decoded single-cycle register
// accesses on core_clk, and that the configuration loader drives the
// range strap and its load strobe on the same clock.
`timescale 1ns/1ps
`include "dbc_cfg.svh"

// What this block does
// - Low nibble of mode selects switching mode
// - Single-phase pair follows channel A registers
// - Mode bit 5: sleep off or pulse-frequency
// - Config bit 0 selects high/low current limit
// - Config bits 3:2 hold frequency selection
// - Config bits 5:4 hold phase clock selection
// - Config bits 7:6 hold ramp speed selection
// - Channel B normal voltage, six bits, writable
// - Normal range bit read-only, set at configuration
// - Channel B standby voltage, six bits, writable
// - Standby range bit copies normal range bit
// - Channel B sleep voltage, six bits, writable
// - Sleep range bit copies normal range bit
module dbc_config_bank
(
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   reset_n,
	// Register access from the control port
	input  wire dbc_pkg::dbc_reg_req_t  req,
	output logic [7:0]                  rdata,
	output logic                        rd_valid,
	// Configuration load of the range strap
	input  wire logic                   cfg_load,
	input  wire logic                   cfg_range_b,
	// Supply topology and device state
	input  wire logic                   single_phase,
	input  wire dbc_pkg::dbc_pwr_state_t pwr_state,
	// Channel A controls (also the combined pair)
	output dbc_pkg::dbc_chan_ctl_t      chan_a_ctl,
	output logic                        chan_a_run,
	output logic                        chan_a_pfm,
	// Channel B controls
	output dbc_pkg::dbc_chan_ctl_t      chan_b_ctl,
	output logic                        chan_b_run,
	output logic                        chan_b_pfm,
	output logic [5:0]                  chan_b_vsel,
	output logic                        chan_b_range
);
	import dbc_pkg::*;

	localparam int NCH = 2;

	function automatic logic addr_is(input logic [7:0] a,
		input logic [7:0] ofs);
		addr_is = (a == ofs);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Channel mode and config pairs
	dbc_chan_ctl_t ctl_w [NCH];
	logic [7:0]    mode_rd_w [NCH];
	logic [7:0]    conf_rd_w [NCH];
	logic [NCH-1:0] chan_hit_w;

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++)
		begin : g_chan
			dbc_chan_regs
			#(
				.MODE_OFS (gi == 0 ? `DBC_OFS_A_MODE : `DBC_OFS_B_MODE),
				.CONF_OFS (gi == 0 ? `DBC_OFS_A_CONF : `DBC_OFS_B_CONF)
			)
			dbc_chan_regs_inst
			(
				.core_clk   (core_clk),
				.reset_n    (reset_n),
				.req        (req),
				.mode_rdata (mode_rd_w[gi]),
				.conf_rdata (conf_rd_w[gi]),
				.hit        (chan_hit_w[gi]),
				.ctl        (ctl_w[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Channel B set points
	logic [5:0] b_volt_r;
	logic [5:0] b_stby_r;
	logic [5:0] b_off_r;
	logic       b_range_r;
	wire        volt_sel;
	wire        stby_sel;
	wire        off_sel;

	assign volt_sel = addr_is(req.addr, `DBC_OFS_B_VOLT);
	assign stby_sel = addr_is(req.addr, `DBC_OFS_B_STBY);
	assign off_sel  = addr_is(req.addr, `DBC_OFS_B_OFF);

	localparam logic [7:0] SETPT_RST = `DBC_SETPT_RST;

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			b_volt_r <= SETPT_RST[5:0];
			b_stby_r <= SETPT_RST[5:0];
			b_off_r  <= SETPT_RST[5:0];
		end
		else if (req.wr)
		begin
			if (volt_sel)
				b_volt_r <= req.wdata[`DBC_VSEL_MSB:`DBC_VSEL_LSB];
			if (stby_sel)
				b_stby_r <= req.wdata[`DBC_VSEL_MSB:`DBC_VSEL_LSB];
			if (off_sel)
				b_off_r <= req.wdata[`DBC_VSEL_MSB:`DBC_VSEL_LSB];
		end
	end

	// Range bit moves only on a configuration load, never by a write
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			b_range_r <= SETPT_RST[`DBC_RANGE_BIT];
		else if (cfg_load)
			b_range_r <= cfg_range_b;
	end

	////////////////////////////////////////////////////////////////////////
	// Read path
	logic [7:0] rd_mux;
	wire        mapped;

	assign mapped = (|chan_hit_w) || volt_sel || stby_sel || off_sel;

	always_comb
	begin
		rd_mux = 8'h00;
		unique case (1'b1)
			addr_is(req.addr, `DBC_OFS_A_MODE): rd_mux = mode_rd_w[0];
			addr_is(req.addr, `DBC_OFS_A_CONF): rd_mux = conf_rd_w[0];
			addr_is(req.addr, `DBC_OFS_B_MODE): rd_mux = mode_rd_w[1];
			addr_is(req.addr, `DBC_OFS_B_CONF): rd_mux = conf_rd_w[1];
			volt_sel: rd_mux = {1'b0, b_range_r, b_volt_r};
			stby_sel: rd_mux = {1'b0, b_range_r, b_stby_r};
			off_sel:  rd_mux = {1'b0, b_range_r, b_off_r};
			default:  rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rdata    <= 8'h00;
			rd_valid <= 1'b0;
		end
		else
		begin
			rd_valid <= req.rd;
			if (req.rd)
				rdata <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Resolved controls
	wire        asleep;
	wire        b_indep;
	logic [5:0] b_vsel_nxt;

	assign asleep  = (pwr_state == DBC_PS_SLEEP);
	assign b_indep = !single_phase;

	always_comb
	begin
		case (pwr_state)
			DBC_PS_NORMAL:  b_vsel_nxt = b_volt_r;
			DBC_PS_STANDBY: b_vsel_nxt = b_stby_r;
			DBC_PS_SLEEP:   b_vsel_nxt = b_off_r;
			default:        b_vsel_nxt = b_volt_r;
		endcase
	end

	// Registered so the analog side sees glitch-free selections
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			chan_a_ctl   <= '0;
			chan_a_run   <= 1'b0;
			chan_a_pfm   <= 1'b0;
			chan_b_ctl   <= '0;
			chan_b_run   <= 1'b0;
			chan_b_pfm   <= 1'b0;
			chan_b_vsel  <= 6'h00;
			chan_b_range <= 1'b0;
		end
		else
		begin
			chan_a_ctl   <= ctl_w[0];
			chan_a_run   <= !asleep || ctl_w[0].sleep_pfm;
			chan_a_pfm   <= asleep && ctl_w[0].sleep_pfm;
			chan_b_ctl   <= b_indep ? ctl_w[1] : '0;
			chan_b_run   <= b_indep && (!asleep || ctl_w[1].sleep_pfm);
			chan_b_pfm   <= b_indep && asleep && ctl_w[1].sleep_pfm;
			chan_b_vsel  <= b_indep ? b_vsel_nxt : 6'h00;
			chan_b_range <= b_indep && b_range_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_unmapped_zero;
		@(posedge core_clk) disable iff (!reset_n)
		(req.rd && !mapped) |=> rd_valid && (rdata == 8'h00);
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero)
		else $error("unmapped read not zero");

	property p_b_idle_single;
		@(posedge core_clk) disable iff (!reset_n)
		single_phase |=> !chan_b_run && !chan_b_pfm
			&& (chan_b_vsel == 6'h00);
	endproperty
	a_b_idle_single: assert property (p_b_idle_single)
		else $error("channel B active in single phase");

	property p_a_sleep_off;
		@(posedge core_clk) disable iff (!reset_n)
		(asleep && !ctl_w[0].sleep_pfm) |=> !chan_a_run && !chan_a_pfm;
	endproperty
	a_a_sleep_off: assert property (p_a_sleep_off)
		else $error("channel A not off in sleep");

	property p_b_sleep_pfm;
		@(posedge core_clk) disable iff (!reset_n)
		(asleep && b_indep && ctl_w[1].sleep_pfm)
			|=> chan_b_run && chan_b_pfm;
	endproperty
	a_b_sleep_pfm: assert property (p_b_sleep_pfm)
		else $error("channel B not in pulse-frequency sleep");

	property p_range_ro;
		@(posedge core_clk) disable iff (!reset_n)
		(req.wr && volt_sel && !cfg_load) |=> $stable(b_range_r);
	endproperty
	a_range_ro: assert property (p_range_ro)
		else $error("range bit changed by write");

	property p_stby_range;
		@(posedge core_clk) disable iff (!reset_n)
		(req.rd && stby_sel) |=> (rdata[6] == $past(b_range_r))
			&& (rdata[5:0] == $past(b_stby_r)) && !rdata[7];
	endproperty
	a_stby_range: assert property (p_stby_range)
		else $error("standby readback wrong");

	property p_off_range;
		@(posedge core_clk) disable iff (!reset_n)
		(req.rd && off_sel) |=> (rdata[6] == $past(b_range_r))
			&& (rdata[5:0] == $past(b_off_r)) && !rdata[7];
	endproperty
	a_off_range: assert property (p_off_range)
		else $error("sleep readback wrong");

	property p_volt_write;
		@(posedge core_clk) disable iff (!reset_n)
		(req.wr && volt_sel) |=> (b_volt_r == $past(req.wdata[5:0]));
	endproperty
	a_volt_write: assert property (p_volt_write)
		else $error("normal set point not stored");

	property p_stby_select;
		@(posedge core_clk) disable iff (!reset_n)
		(b_indep && pwr_state == DBC_PS_STANDBY)
			|=> (chan_b_vsel == $past(b_stby_r));
	endproperty
	a_stby_select: assert property (p_stby_select)
		else $error("standby set point not applied");

	property p_sleep_select;
		@(posedge core_clk) disable iff (!reset_n)
		(b_indep && asleep) |=> (chan_b_vsel == $past(b_off_r));
	endproperty
	a_sleep_select: assert property (p_sleep_select)
		else $error("sleep set point not applied");

	property p_ilim_out;
		@(posedge core_clk) disable iff (!reset_n)
		(req.wr && addr_is(req.addr, `DBC_OFS_A_CONF))
			##1 1'b1 |=> (chan_a_ctl.ilim_low == $past(req.wdata[0], 2));
	endproperty
	a_ilim_out: assert property (p_ilim_out)
		else $error("current limit select not applied");

	property p_conf_spare;
		@(posedge core_clk) disable iff (!reset_n)
		(req.wr && addr_is(req.addr, `DBC_OFS_B_CONF))
			|=> (conf_rd_w[1][1] == $past(req.wdata[1]));
	endproperty
	a_conf_spare: assert property (p_conf_spare)
		else $error("config spare bit not stored");

	property p_phase_out;
		@(posedge core_clk) disable iff (!reset_n)
		(req.wr && addr_is(req.addr, `DBC_OFS_A_CONF)) ##1 !req.wr
			|=> (chan_a_ctl.phase == $past(req.wdata[5:4], 2))
			&& (chan_a_ctl.ramp == $past(req.wdata[7:6], 2));
	endproperty
	a_phase_out: assert property (p_phase_out)
		else $error("phase or ramp select not applied");

endmodule

// >>> include/dbc_cfg.svh
// Offsets, field positions and reset values of the dual buck config bank.
// Assumes an 8-bit register address space and 8-bit register data.
`ifndef DBC_CFG_SVH
`define DBC_CFG_SVH

// Register offsets
`define DBC_OFS_A_MODE   8'h3f
`define DBC_OFS_A_CONF   8'h40
`define DBC_OFS_B_VOLT   8'h43
`define DBC_OFS_B_STBY   8'h44
`define DBC_OFS_B_OFF    8'h45
`define DBC_OFS_B_MODE   8'h46
`define DBC_OFS_B_CONF   8'h47

// Mode register fields
`define DBC_MODE_MSB     3
`define DBC_MODE_LSB     0
`define DBC_SLEEP_BIT    5

// Config register fields
`define DBC_ILIM_BIT     0
`define DBC_SPARE_BIT    1
`define DBC_FREQ_MSB     3
`define DBC_FREQ_LSB     2
`define DBC_PHASE_MSB    5
`define DBC_PHASE_LSB    4
`define DBC_RAMP_MSB     7
`define DBC_RAMP_LSB     6

// Set-point register fields
`define DBC_VSEL_MSB     5
`define DBC_VSEL_LSB     0
`define DBC_RANGE_BIT    6

// Reset values
`define DBC_MODE_RST     8'h80
`define DBC_CONF_RST     8'h00
`define DBC_SETPT_RST    8'h00

`endif

// >>> include/dbc_pkg.sv
// Types shared by the dual buck config bank and its channel register slice.
// Assumes nothing beyond a SystemVerilog-2012 compiler.
package dbc_pkg;

	// Operating state of the device as seen by this bank
	typedef enum logic [1:0]
	{
		DBC_PS_NORMAL,
		DBC_PS_STANDBY,
		DBC_PS_SLEEP
	} dbc_pwr_state_t;

	// One register access from the serial control port
	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dbc_reg_req_t;

	// Per-channel switching controls
	typedef struct packed
	{
		logic [3:0] mode;
		logic       sleep_pfm;
		logic       ilim_low;
		logic       conf_spare;
		logic [1:0] freq;
		logic [1:0] phase;
		logic [1:0] ramp;
	} dbc_chan_ctl_t;

endpackage

// >>> design/dbc_chan_regs.sv
// Mode and config register pair of one buck channel.
// Assumes requests arrive synchronous to core_clk from the control port.
`timescale 1ns/1ps
`include "dbc_cfg.svh"

module dbc_chan_regs
#(
	parameter logic [7:0] MODE_OFS = `DBC_OFS_A_MODE,
	parameter logic [7:0] CONF_OFS = `DBC_OFS_A_CONF
)
(
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   reset_n,
	// Register access
	input  wire dbc_pkg::dbc_reg_req_t  req,
	// Read views and controls
	output logic [7:0]                  mode_rdata,
	output logic [7:0]                  conf_rdata,
	output logic                        hit,
	output dbc_pkg::dbc_chan_ctl_t      ctl
);
	import dbc_pkg::*;

	localparam logic [7:0] MODE_RST = `DBC_MODE_RST;

	logic [3:0] mode_r;
	logic       sleep_r;
	logic [7:0] conf_r;
	wire        mode_wr;
	wire        conf_wr;

	////////////////////////////////////////////////////////////////////////
	assign mode_wr = req.wr && (req.addr == MODE_OFS);
	assign conf_wr = req.wr && (req.addr == CONF_OFS);
	assign hit     = (req.addr == MODE_OFS) || (req.addr == CONF_OFS);

	// Field only holds the low nibble of the 0x80 default
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mode_r  <= MODE_RST[`DBC_MODE_MSB:`DBC_MODE_LSB];
			sleep_r <= 1'b0;
			conf_r  <= `DBC_CONF_RST;
		end
		else
		begin
			if (mode_wr)
			begin
				mode_r  <= req.wdata[`DBC_MODE_MSB:`DBC_MODE_LSB];
				sleep_r <= req.wdata[`DBC_SLEEP_BIT];
			end
			if (conf_wr)
				conf_r <= req.wdata;
		end
	end

	// Bits 4, 6 and 7 of mode stay zero
	assign mode_rdata = {2'b00, sleep_r, 1'b0, mode_r};
	assign conf_rdata = conf_r;

	assign ctl.mode       = mode_r;
	assign ctl.sleep_pfm  = sleep_r;
	assign ctl.ilim_low   = conf_r[`DBC_ILIM_BIT];
	assign ctl.conf_spare = conf_r[`DBC_SPARE_BIT];
	assign ctl.freq       = conf_r[`DBC_FREQ_MSB:`DBC_FREQ_LSB];
	assign ctl.phase      = conf_r[`DBC_PHASE_MSB:`DBC_PHASE_LSB];
	assign ctl.ramp       = conf_r[`DBC_RAMP_MSB:`DBC_RAMP_LSB];

	////////////////////////////////////////////////////////////////////////
	property p_mode_store;
		@(posedge core_clk) disable iff (!reset_n)
		mode_wr |=> (ctl.mode == $past(req.wdata[3:0]))
			&& (ctl.sleep_pfm == $past(req.wdata[5]));
	endproperty
	a_mode_store: assert property (p_mode_store)
		else $error("mode write not stored");

	property p_conf_fields;
		@(posedge core_clk) disable iff (!reset_n)
		conf_wr |=> (ctl.freq == $past(req.wdata[3:2]))
			&& (ctl.phase == $past(req.wdata[5:4]))
			&& (ctl.ramp == $past(req.wdata[7:6]))
			&& (ctl.ilim_low == $past(req.wdata[0]));
	endproperty
	a_conf_fields: assert property (p_conf_fields)
		else $error("config fields not stored");

	property p_mode_hold;
		@(posedge core_clk) disable iff (!reset_n)
		!mode_wr |=> $stable(mode_rdata) && (mode_rdata[7:6] == 2'b00)
			&& !mode_rdata[4];
	endproperty
	a_mode_hold: assert property (p_mode_hold)
		else $error("mode register changed without write");

endmodule

// >>> sim/dbc_host_model.sv
// Host processor model driving the register port of the config bank.
// Assumes core_clk from the bench and a registered read answer.
`timescale 1ns/1ps

module dbc_host_model
(
	// Clock
	input  wire logic                   core_clk,
	// Register port
	output dbc_pkg::dbc_reg_req_t       req,
	input  wire logic [7:0]             rdata,
	input  wire logic                   rd_valid
);
	import dbc_pkg::*;

	initial req = '0;

	////////////////////////////////////////////////////////////////////////
	// One access; the read answer is awaited for a few cycles only
	task automatic access(input logic w, input logic r, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic ok);
		int i;
		q = 8'h00;
		ok = 1'b1;
		@(posedge core_clk);
		#1;
		req = '{wr: w, rd: r, addr: a, wdata: d};
		@(posedge core_clk);
		#1;
		req.wr = 1'b0;
		req.rd = 1'b0;
		// Released lines scrambled so nothing leans on stale values
		req.addr = ~a;
		req.wdata = ~d;
		if (r)
		begin
			ok = 1'b0;
			for (i = 0; i < 4 && !ok; i++)
			begin
				if (rd_valid === 1'b1)
				begin
					// Answer is due exactly one cycle after the strobe
					q = rdata;
					ok = (i == 0);
					break;
				end
				else
				begin
					@(posedge core_clk);
					#1;
				end
			end
		end
	endtask
endmodule

// >>> sim/dbc_config_bank_bench.sv
// Self-checking bench of the dual buck config bank.
// Assumes the host model for register traffic; bench drives the rest.
`timescale 1ns/1ps
`include "dbc_cfg.svh"

`define CHK(what, exp, got) \
begin \
	checks_done++; \
	if ((got) !== (exp)) \
	begin \
		n_mismatch++; \
		$display("mismatch %s expected %h seen %h", what, exp, got); \
	end \
end

module dbc_config_bank_bench;
	import dbc_pkg::*;

	logic           core_clk;
	logic           reset_n;
	dbc_reg_req_t   req;
	logic [7:0]     rdata;
	logic           rd_valid;
	logic           cfg_load;
	logic           cfg_range_b;
	logic           single_phase;
	dbc_pwr_state_t pwr_state;
	dbc_chan_ctl_t  chan_a_ctl;
	dbc_chan_ctl_t  chan_b_ctl;
	logic           chan_a_run;
	logic           chan_a_pfm;
	logic           chan_b_run;
	logic           chan_b_pfm;
	logic [5:0]     chan_b_vsel;
	logic           chan_b_range;
	int             n_mismatch;
	int             checks_done;
	// Expected register images
	logic [7:0]     m_a_mode;
	logic [7:0]     m_a_conf;
	logic [7:0]     m_b_mode;
	logic [7:0]     m_b_conf;
	logic [5:0]     m_volt;
	logic [5:0]     m_stby;
	logic [5:0]     m_off;
	logic           m_range;
	logic [7:0]     addrs [11] = '{`DBC_OFS_A_MODE, `DBC_OFS_A_CONF,
		`DBC_OFS_B_VOLT, `DBC_OFS_B_STBY, `DBC_OFS_B_OFF, `DBC_OFS_B_MODE,
		`DBC_OFS_B_CONF, 8'h41, 8'h42, 8'h00, 8'hff};

	always #10 core_clk = ~core_clk;

	dbc_config_bank dbc_config_bank_inst
	(
		.core_clk     (core_clk),
		.reset_n      (reset_n),
		.req          (req),
		.rdata        (rdata),
		.rd_valid     (rd_valid),
		.cfg_load     (cfg_load),
		.cfg_range_b  (cfg_range_b),
		.single_phase (single_phase),
		.pwr_state    (pwr_state),
		.chan_a_ctl   (chan_a_ctl),
		.chan_a_run   (chan_a_run),
		.chan_a_pfm   (chan_a_pfm),
		.chan_b_ctl   (chan_b_ctl),
		.chan_b_run   (chan_b_run),
		.chan_b_pfm   (chan_b_pfm),
		.chan_b_vsel  (chan_b_vsel),
		.chan_b_range (chan_b_range)
	);

	dbc_host_model dbc_host_model_inst
	(
		.core_clk (core_clk),
		.req      (req),
		.rdata    (rdata),
		.rd_valid (rd_valid)
	);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		case (a)
			`DBC_OFS_A_MODE: exp_rd = m_a_mode;
			`DBC_OFS_A_CONF: exp_rd = m_a_conf;
			`DBC_OFS_B_VOLT: exp_rd = {1'b0, m_range, m_volt};
			`DBC_OFS_B_STBY: exp_rd = {1'b0, m_range, m_stby};
			`DBC_OFS_B_OFF:  exp_rd = {1'b0, m_range, m_off};
			`DBC_OFS_B_MODE: exp_rd = m_b_mode;
			`DBC_OFS_B_CONF: exp_rd = m_b_conf;
			default:         exp_rd = 8'h00;
		endcase
	endfunction

	function automatic dbc_chan_ctl_t exp_ctl(input logic [7:0] m,
		input logic [7:0] c);
		exp_ctl = '{m[3:0], m[5], c[0], c[1], c[3:2], c[5:4], c[7:6]};
	endfunction

	task automatic model_wr(input logic [7:0] a, input logic [7:0] d);
		case (a)
			`DBC_OFS_A_MODE: m_a_mode = d & 8'h2f;
			`DBC_OFS_A_CONF: m_a_conf = d;
			`DBC_OFS_B_VOLT: m_volt = d[5:0];
			`DBC_OFS_B_STBY: m_stby = d[5:0];
			`DBC_OFS_B_OFF:  m_off = d[5:0];
			`DBC_OFS_B_MODE: m_b_mode = d & 8'h2f;
			`DBC_OFS_B_CONF: m_b_conf = d;
			default:         m_range = m_range;
		endcase
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic reg_op(input logic w, input logic r, input logic [7:0] a,
		input logic [7:0] d);
		logic [7:0] q;
		logic       ok;
		logic [7:0] e;
		// Expectation taken first: a same-cycle read sees the old value
		e = exp_rd(a);
		dbc_host_model_inst.access(w, r, a, d, q, ok);
		if (w)
			model_wr(a, d);
		if (r && !ok)
		begin
			n_mismatch++;
			tally_and_finish();
		end
		if (r)
			`CHK("rdata", e, q)
	endtask

	task automatic do_reset();
		reset_n = 1'b0;
		{m_a_mode, m_a_conf, m_b_mode, m_b_conf} = 32'h0000_0000;
		{m_volt, m_stby, m_off, m_range} = 19'h0_0000;
		repeat (16) @(posedge core_clk);
		#1;
		reset_n = 1'b1;
	endtask

	task automatic cfg_drive(input logic v);
		@(posedge core_clk);
		#1;
		cfg_load = 1'b1;
		cfg_range_b = v;
		@(posedge core_clk);
		#1;
		cfg_load = 1'b0;
		cfg_range_b = ~v;
		m_range = v;
	endtask

	task automatic check_outs();
		logic          sl;
		dbc_chan_ctl_t bc;
		logic [5:0]    bv;
		repeat (3) @(posedge core_clk);
		#1;
		sl = (pwr_state == DBC_PS_SLEEP);
		bv = sl ? m_off : (pwr_state == DBC_PS_STANDBY) ? m_stby : m_volt;
		bc = single_phase ? 13'h0000 : exp_ctl(m_b_mode, m_b_conf);
		`CHK("a_ctl", exp_ctl(m_a_mode, m_a_conf), chan_a_ctl)
		`CHK("a_run", !sl || m_a_mode[5], chan_a_run)
		`CHK("a_pfm", sl && m_a_mode[5], chan_a_pfm)
		`CHK("b_ctl", bc, chan_b_ctl)
		`CHK("b_run", !single_phase && (!sl || m_b_mode[5]), chan_b_run)
		`CHK("b_pfm", !single_phase && sl && m_b_mode[5], chan_b_pfm)
		`CHK("b_vsel", single_phase ? 6'h00 : bv, chan_b_vsel)
		`CHK("b_range", !single_phase && m_range, chan_b_range)
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		#(20 * 60000);
		n_mismatch++;
		tally_and_finish();
	end

	initial
	begin
		logic [7:0] a;
		logic       w;
		int         i;
		int         k;
		core_clk = 1'b0;
		cfg_load = 1'b0;
		cfg_range_b = 1'b0;
		single_phase = 1'b0;
		pwr_state = DBC_PS_NORMAL;
		n_mismatch = 0;
		checks_done = 0;
		void'($urandom(32'he6a6));
		do_reset();
		// Reset values, unmapped places included
		for (i = 0; i < 11; i++)
			reg_op(1'b0, 1'b1, addrs[i], 8'h00);
		// All ones: unused and range bits stay clear, spare bit kept
		for (i = 0; i < 11; i++)
			reg_op(1'b1, 1'b0, addrs[i], 8'hff);
		for (i = 0; i < 11; i++)
			reg_op(1'b0, 1'b1, addrs[i], 8'h00);
		// Loaded range shows in all three set points; writes cannot clear it
		cfg_drive(1'b1);
		for (i = 2; i < 5; i++)
			reg_op(1'b1, 1'b1, addrs[i], 8'h00);
		for (i = 2; i < 5; i++)
			reg_op(1'b0, 1'b1, addrs[i], 8'h00);
		// Write and read in one cycle, then random traffic, one idle cycle between accesses
		reg_op(1'b1, 1'b1, `DBC_OFS_A_CONF, 8'h5a);
		for (i = 0; i < 80; i++)
		begin
			a = addrs[$urandom_range(10)];
			w = 1'($urandom_range(1));
			reg_op(w, !w || $urandom_range(1), a, 8'($urandom));
		end
		// Outputs over every state, both topologies, both sleep choices
		for (k = 0; k < 18; k++)
		begin
			for (i = 0; i < 7; i++)
				reg_op(1'b1, 1'b0, addrs[i], 8'($urandom));
			cfg_drive(1'($urandom_range(1)));
			pwr_state = dbc_pwr_state_t'(k % 3);
			single_phase = 1'((k / 3) % 2);
			check_outs();
		end
		// Reset in mid-run clears the bank again
		do_reset();
		for (i = 0; i < 7; i++)
			reg_op(1'b0, 1'b1, addrs[i], 8'h00);
		// Resolved outputs fall back to the cleared register images
		check_outs();
		tally_and_finish();
	end
endmodule
